// [rtl/dlcg_mem.sv]
// Purpose: list memory holding instruction words
// Assumes: one write port from the host, one read port for fetch
// Notes: read data registered, one cycle after the address
`timescale 1ns/1ps
module dlcg_mem #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input  wire logic          aclk,
    input  wire logic          ce,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge aclk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : dlcg_mem

// [rtl/dlcg_pkg.sv]
// Purpose: shared constants and helpers for the display list coprocessor
// Assumes: AXI4-Lite register map, 16-bit list words, 9-bit chip offsets
// Notes: list pointers and the program counter are word indices
//
// Operation
// - offsets 80h..FFh and above always writable
// - offsets 00h..3Eh never written by list
// - offsets 40h..7Eh writable only when danger set
// - danger flag is control bit 1 only
// - danger flag clears at reset
// - wait ends when beam at or past target
// - moves after a wait run back to back
// - beam runs 0,0 to 226,262 or 312
// - move word one is offset, word two data
// - wait FFFF,FFFE stalls until the restart
// - wait 9601,FF00 waits line 150, ignores horizontal
// - list fetched only from list memory
// - list run once per frame in beam order
// - wait word fields: targets and compare enables
// - vertical blank start reloads pc from first pointer
// - jump strobe write loads matching pointer into pc
// - horizontal lsb excluded from wait compare
package dlcg_pkg;
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_LIST1  = 8'h04;
    localparam logic [7:0] OFS_LIST2  = 8'h08;
    localparam logic [7:0] OFS_JUMP1  = 8'h0c;
    localparam logic [7:0] OFS_JUMP2  = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MADDR  = 8'h18;
    localparam logic [7:0] OFS_MDATA  = 8'h1c;
    localparam logic [7:0] OFS_RUN    = 8'h20;

    localparam int DANGER_BIT = 1;
    localparam int RUN_BIT    = 0;
    localparam int WAITING_BIT = 31;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    localparam logic [8:0] CHIP_NEVER_HI  = 9'h03e;
    localparam logic [8:0] CHIP_DANGER_LO = 9'h040;
    localparam logic [8:0] CHIP_DANGER_HI = 9'h07e;
    localparam logic [8:0] CHIP_ALWAYS_LO = 9'h080;
    localparam logic [8:0] CHIP_JUMP1     = 9'h088;
    localparam logic [8:0] CHIP_JUMP2     = 9'h08a;

    localparam int W_TYPE_BIT = 0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_RD1, ST_RD2, ST_LD2, ST_EXEC} dlcg_state_e;

    // masked position compare; bit 15 of word two is not a mask bit,
    // so vertical bit 7, the top compared bit, always takes part
    function automatic logic dlcg_beam_ge(input logic [15:0] w1,
                                          input logic [15:0] w2,
                                          input logic [7:0]  h,
                                          input logic [8:0]  v);
        logic [14:0] beam;
        logic [14:0] tgt;
        logic [14:0] msk;
        msk  = {1'b1, w2[14:1]};
        beam = {v[7:0], h[7:1]} & msk;
        tgt  = w1[15:1] & msk;
        return beam >= tgt;
    endfunction : dlcg_beam_ge

    function automatic logic dlcg_write_ok(input logic [8:0] ofs,
                                           input logic danger);
        logic ok;
        ok = 1'b0;
        if (ofs >= CHIP_ALWAYS_LO)
            ok = 1'b1;
        else if (ofs >= CHIP_DANGER_LO && ofs <= CHIP_DANGER_HI)
            ok = danger;
        else if (ofs <= CHIP_NEVER_HI)
            ok = 1'b0;
        return ok;
    endfunction : dlcg_write_ok
endpackage : dlcg_pkg

// [rtl/dlcg_top.sv]
// Purpose: display list coprocessor with protected chip register writes
// Assumes: beam counters and vblank strobe synchronous to aclk
// Notes: runs only while the run register bit is set
`timescale 1ns/1ps
module dlcg_top
    import dlcg_pkg::*;
#(
    parameter int AW = 10
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        ce,
    input  wire logic [dlcg_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [dlcg_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [7:0]                  beam_h,
    input  wire logic [8:0]                  beam_v,
    input  wire logic                        vblank_start,
    output logic                             chip_wr_valid,
    output logic [8:0]                       chip_wr_offset,
    output logic [15:0]                      chip_wr_data,
    output logic                             move_blocked
);
    import dlcg_pkg::*;

    // bus side holding registers
    logic                        aw_full_reg;
    logic [AXI_AW-1:0]           aw_addr_reg;
    logic                        w_full_reg;
    logic [31:0]                 w_data_reg;
    logic [3:0]                  w_strb_reg;
    logic                        bvalid_reg;
    logic [1:0]                  bresp_reg;
    logic                        rvalid_reg;
    logic [31:0]                 rdata_reg;
    logic [1:0]                  rresp_reg;
    logic                        do_write;
    logic                        wr_mapped;

    // software visible state
    logic [15:0]                 coproc_control_reg;
    logic                        run_reg;
    logic [AW-1:0]               first_list_pointer_reg;
    logic [AW-1:0]               second_list_pointer_reg;
    logic [AW-1:0]               mem_addr_reg;

    // engine
    dlcg_state_e                 state_reg;
    logic [AW-1:0]               pc_reg;
    logic [15:0]                 word1_reg;
    logic [15:0]                 word2_reg;
    logic [AW-1:0]               rd_addr;
    logic [15:0]                 rd_data;
    logic                        host_jump1;
    logic                        host_jump2;
    logic                        move_jump1;
    logic                        move_jump2;
    logic                        is_wait;
    logic                        wait_hit;
    logic                        move_ok;
    logic                        mem_wr;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0]) r[7:0]  = d[7:0];
        if (s[1]) r[15:8] = d[15:8];
        return r;
    endfunction : merge16

    function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
        return a == OFS_CTRL || a == OFS_LIST1 || a == OFS_LIST2
            || a == OFS_JUMP1 || a == OFS_JUMP2 || a == OFS_STATUS
            || a == OFS_MADDR || a == OFS_MDATA || a == OFS_RUN;
    endfunction : is_mapped

    // axi4-lite write path
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready  = !w_full_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign do_write      = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_mapped     = is_mapped(aw_addr_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (ce) begin
            if (s_axi_wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // register writes
    assign host_jump1 = do_write && aw_addr_reg == OFS_JUMP1;
    assign host_jump2 = do_write && aw_addr_reg == OFS_JUMP2;
    assign mem_wr     = do_write && aw_addr_reg == OFS_MDATA
                        && w_strb_reg[1:0] != 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            coproc_control_reg <= CTRL_RESET;
        end else if (ce && do_write && aw_addr_reg == OFS_CTRL) begin
            // only the danger flag is kept; other bits read zero
            coproc_control_reg <= merge16(coproc_control_reg, w_data_reg,
                w_strb_reg) & (16'h0001 << DANGER_BIT);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_reg <= 1'b0;
        end else if (ce && do_write && aw_addr_reg == OFS_RUN
                     && w_strb_reg[0]) begin
            run_reg <= w_data_reg[RUN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_list_pointer_reg  <= '0;
            second_list_pointer_reg <= '0;
        end else if (ce && do_write) begin
            if (aw_addr_reg == OFS_LIST1)
                first_list_pointer_reg <= AW'(merge16(
                    16'(first_list_pointer_reg), w_data_reg, w_strb_reg));
            if (aw_addr_reg == OFS_LIST2)
                second_list_pointer_reg <= AW'(merge16(
                    16'(second_list_pointer_reg), w_data_reg, w_strb_reg));
        end
    end

    // list loading: data port auto-increments the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_addr_reg <= '0;
        end else if (ce) begin
            if (do_write && aw_addr_reg == OFS_MADDR)
                mem_addr_reg <= AW'(merge16(16'(mem_addr_reg), w_data_reg,
                                            w_strb_reg));
            else if (mem_wr)
                mem_addr_reg <= mem_addr_reg + AW'(1);
        end
    end

    // axi4-lite read path
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && !rvalid_reg) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= is_mapped(s_axi_araddr) ? RESP_OKAY
                                                      : RESP_SLVERR;
                rdata_reg  <= '0;
                unique case (s_axi_araddr)
                    OFS_CTRL:   rdata_reg <= 32'(coproc_control_reg);
                    OFS_RUN:    rdata_reg <= 32'(run_reg);
                    OFS_LIST1:  rdata_reg <= 32'(first_list_pointer_reg);
                    OFS_LIST2:  rdata_reg <= 32'(second_list_pointer_reg);
                    OFS_MADDR:  rdata_reg <= 32'(mem_addr_reg);
                    OFS_STATUS: begin
                        rdata_reg <= 32'(pc_reg);
                        rdata_reg[WAITING_BIT] <= state_reg == ST_EXEC
                                                  && is_wait && !wait_hit;
                    end
                    default:    rdata_reg <= '0;
                endcase
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // list memory
    dlcg_mem #(
        .AW (AW),
        .DW (16)
    ) u_mem (
        .aclk    (aclk),
        .ce      (ce),
        .wr_en   (mem_wr),
        .wr_addr (mem_addr_reg),
        .wr_data (w_data_reg[15:0]),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // instruction engine
    // word two stays addressed while waiting so rd_data holds it
    assign rd_addr  = (state_reg == ST_RD1) ? pc_reg : pc_reg + AW'(1);
    assign is_wait  = word1_reg[W_TYPE_BIT];
    // beam counters are 8-bit h (to e2) and low 8 bits of v
    assign wait_hit = dlcg_beam_ge(word1_reg, word2_reg, beam_h,
                                   beam_v);
    assign move_ok  = dlcg_write_ok(word1_reg[8:0],
                                    coproc_control_reg[DANGER_BIT]);
    assign move_jump1 = state_reg == ST_EXEC && !is_wait && move_ok
                        && word1_reg[8:0] == CHIP_JUMP1;
    assign move_jump2 = state_reg == ST_EXEC && !is_wait && move_ok
                        && word1_reg[8:0] == CHIP_JUMP2;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_RD1;
            pc_reg    <= '0;
            word1_reg <= '0;
            word2_reg <= '0;
        end else if (ce) begin
            if (vblank_start) begin
                // restart wins over anything in flight
                pc_reg    <= first_list_pointer_reg;
                state_reg <= ST_RD1;
            end else if (host_jump1 || move_jump1) begin
                pc_reg    <= first_list_pointer_reg;
                state_reg <= ST_RD1;
            end else if (host_jump2 || move_jump2) begin
                pc_reg    <= second_list_pointer_reg;
                state_reg <= ST_RD1;
            end else if (run_reg) begin
                unique case (state_reg)
                    ST_RD1: state_reg <= ST_RD2;
                    ST_RD2: begin
                        word1_reg <= rd_data;
                        state_reg <= ST_LD2;
                    end
                    ST_LD2: begin
                        word2_reg <= rd_data;
                        state_reg <= ST_EXEC;
                    end
                    ST_EXEC: begin
                        // unreachable target simply never hits
                        if (!is_wait || wait_hit) begin
                            pc_reg    <= pc_reg + AW'(2);
                            state_reg <= ST_RD1;
                        end
                    end
                endcase
            end
        end
    end

    // chip register write port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chip_wr_valid  <= 1'b0;
            chip_wr_offset <= '0;
            chip_wr_data   <= '0;
            move_blocked   <= 1'b0;
        end else if (ce) begin
            chip_wr_valid <= 1'b0;
            move_blocked  <= 1'b0;
            if (run_reg && !vblank_start && state_reg == ST_EXEC
                && !is_wait) begin
                if (move_ok) begin
                    chip_wr_valid  <= 1'b1;
                    chip_wr_offset <= word1_reg[8:0];
                    chip_wr_data   <= word2_reg;
                end else begin
                    move_blocked <= 1'b1;
                end
            end
        end
    end
endmodule : dlcg_top

// [sim/dlcg_beam.sv]
// Purpose: beam counter model for the video timing side
// Assumes: one horizontal count per aclk cycle
// Notes: load port jumps the beam so tests skip most of a frame
`timescale 1ns/1ps
module dlcg_beam #(
    parameter logic [7:0] H_LAST = 8'he2,
    parameter logic [8:0] V_LAST = 9'h106
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ld,
    input  wire logic [7:0] ld_h,
    input  wire logic [8:0] ld_v,
    output logic      [7:0] beam_h,
    output logic      [8:0] beam_v,
    output logic            vblank_start
);
    always_ff @(posedge aclk) begin
        vblank_start <= 1'b0;
        if (!aresetn) begin
            beam_h <= 8'h00;
            beam_v <= 9'h000;
        end else if (ld) begin
            beam_h <= ld_h;
            beam_v <= ld_v;
        end else if (beam_h != H_LAST) begin
            beam_h <= beam_h + 8'h01;
        end else begin
            beam_h <= 8'h00;
            beam_v <= (beam_v == V_LAST) ? 9'h000 : beam_v + 9'h001;
            vblank_start <= (beam_v == V_LAST);
        end
    end
endmodule : dlcg_beam

// [sim/dlcg_chk.sv]
// Purpose: port checks for the display list coprocessor
// Assumes: ce held high, control written with aw and w together
// Notes: danger flag shadowed from host writes to the control register
`timescale 1ns/1ps
module dlcg_chk
    import dlcg_pkg::*;
(
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic [dlcg_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic [31:0]                 s_axi_wdata,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic [dlcg_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [31:0]                 s_axi_rdata,
    input wire logic [1:0]                  s_axi_rresp,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic                        chip_wr_valid,
    input wire logic [8:0]                  chip_wr_offset,
    input wire logic                        move_blocked
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic dng_reg;
    logic wr_take;
    assign wr_take = s_axi_awvalid && s_axi_awready
                     && s_axi_wvalid && s_axi_wready;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            dng_reg <= 1'b0;
        else if (wr_take && s_axi_awaddr == OFS_CTRL)
            dng_reg <= s_axi_wdata[DANGER_BIT];
    end
    never_range_a: assert property (chip_wr_valid |->
        chip_wr_offset > CHIP_NEVER_HI) else $error("never range written");
    danger_gate_a: assert property (chip_wr_valid
        && chip_wr_offset inside {[CHIP_DANGER_LO:CHIP_DANGER_HI]}
        |-> dng_reg) else $error("guarded range written without danger");
    one_result_a: assert property (
        !(chip_wr_valid && move_blocked)) else $error("write and discard");
    move_space_a: assert property ((chip_wr_valid || move_blocked)
        |=> !(chip_wr_valid || move_blocked) [*3])
        else $error("moves closer than four cycles");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer moved");
    wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr > OFS_RUN |=> s_axi_rresp == RESP_SLVERR
        && s_axi_rdata == 32'h0) else $error("unmapped read answered");
endmodule : dlcg_chk

bind dlcg_top dlcg_chk u_chk (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .chip_wr_valid, .chip_wr_offset, .move_blocked
);

// [sim/dlcg_top_tb.sv]
// Purpose: self-checking bench for the coprocessor guard
// Assumes: ce tied high, full strobes on every host write
// Notes: expected chip writes queued from the list as it is built
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module dlcg_top_tb;
    import dlcg_pkg::*;
    logic aclk, aresetn = 1'b0, ce = 1'b1, ld = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ld_h = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, chip_wr_valid, move_blocked, vblank_start;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [8:0] chip_wr_offset, beam_v, ld_v = 9'h000;
    logic [15:0] chip_wr_data, lst[$];
    logic [7:0] beam_h;
    logic [33:0] exp_q[$], e;
    logic [25:0] got;
    logic [31:0] seed = 32'h99eb;
    logic [8:0] ofs [0:6] = '{9'h000, 9'h03e, 9'h040, 9'h07e,
                              9'h080, 9'h0fe, 9'h1fe};
    int n_fail = 0, cmp_count = 0, dng = 0, minv = 0;
    dlcg_top #(.AW(10)) DUT (
        .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .beam_h,
        .beam_v, .vblank_start, .chip_wr_valid, .chip_wr_offset,
        .chip_wr_data, .move_blocked);
    dlcg_beam u_beam (.aclk, .aresetn, .ld, .ld_h, .ld_v, .beam_h, .beam_v,
        .vblank_start);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    function automatic logic [15:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed[15:0];
    endfunction : rnd
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 || s_axi_awvalid || s_axi_wvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 || s_axi_arvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // guard model: blocked moves carry no payload
    task automatic mv(input logic [8:0] o, input logic [15:0] d);
        logic b;
        b = !(o >= 9'h080 || (o >= 9'h040 && o <= 9'h07e && dng != 0));
        lst.push_back({7'h00, o});
        lst.push_back(d);
        if (o != CHIP_JUMP1 && o != CHIP_JUMP2)
            exp_q.push_back({minv[7:0], b, b ? 25'h0 : {o, d}});
    endtask : mv
    task automatic wt(input logic [15:0] a, input logic [15:0] b,
                      input int m);
        lst.push_back(a);
        lst.push_back(b);
        minv = m;
    endtask : wt
    task automatic flush(input logic [31:0] base);
        wr(OFS_MADDR, base, rr);
        foreach (lst[k]) wr(OFS_MDATA, {16'h0, lst[k]}, rr);
        lst.delete();
    endtask : flush
    task automatic jump_beam(input logic [8:0] v, input logic [7:0] h);
        @(posedge aclk);
        ld <= 1'b1;
        ld_v <= v;
        ld_h <= h;
        @(posedge aclk);
        ld <= 1'b0;
    endtask : jump_beam
    task automatic drain(input string nm);
        repeat (2000) if (exp_q.size() != 0) @(posedge aclk);
        repeat (40) @(posedge aclk);
        `CHK(exp_q.size(), 0)
        $display("end of test %s", nm);
    endtask : drain
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // unexpected pulses meet an all-ones expectation and fail
    always @(posedge aclk) begin
        if (aresetn && (move_blocked === 1'b1 || (chip_wr_valid === 1'b1
            && chip_wr_offset != CHIP_JUMP1
            && chip_wr_offset != CHIP_JUMP2))) begin
            got = move_blocked ? 26'h2000000
                               : {1'b0, chip_wr_offset, chip_wr_data};
            e = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
            `CHK(got, e[25:0])
            `CHK(beam_v[7:0] >= e[33:26], 1'b1)
        end
    end
    initial begin
        repeat (30000) @(posedge aclk);
        n_fail++;
        $display("ERROR t=%0t watchdog expired", $time);
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_CTRL, rv, rr);
        `CHK(rv[15:0], CTRL_RESET)
        wr(OFS_CTRL, 32'hfffd, rr);
        rd(OFS_CTRL, rv, rr);
        `CHK(rv, 32'h0)
        rd(8'h40, rv, rr);
        `CHK({rr, rv}, {RESP_SLVERR, 32'h0})
        wr(8'h44, 32'h1, rr);
        `CHK(rr, RESP_SLVERR)
        $display("end of test registers");
        foreach (ofs[i]) mv(ofs[i], rnd());
        wt(16'hffff, 16'hfffe, 0);
        flush(0);
        jump_beam(9'h00a, 8'h00);
        wr(OFS_LIST1, 32'h0, rr);
        wr(OFS_JUMP1, 32'h0, rr);
        wr(OFS_RUN, 32'h1, rr);
        drain("closed range");
        wr(OFS_CTRL, 32'h2, rr);
        rd(OFS_CTRL, rv, rr);
        `CHK(rv, 32'h2)
        dng = 1;
        foreach (ofs[i]) mv(ofs[i], rnd());
        wt(16'hffff, 16'hfffe, 0);
        flush(0);
        jump_beam(9'h106, 8'he2);
        drain("open range");
        wt(16'h9601, 16'hff00, 150);
        mv(9'h180, rnd());
        mv(9'h182, rnd());
        wt(16'h2001, 16'hfffe, 150);
        mv(9'h184, rnd());
        wt(16'hffff, 16'hfffe, 0);
        flush(64);
        wr(OFS_LIST1, 32'd64, rr);
        jump_beam(9'h095, 8'h00);
        wr(OFS_JUMP1, 32'h0, rr);
        drain("waits");
        mv(CHIP_JUMP2, 16'h0);
        lst.push_back(16'h0190);
        lst.push_back(16'h1234);
        flush(128);
        mv(9'h186, rnd());
        wt(16'hffff, 16'hfffe, 0);
        flush(160);
        wr(OFS_LIST2, 32'd160, rr);
        wr(OFS_LIST1, 32'd128, rr);
        wr(OFS_JUMP1, 32'h0, rr);
        drain("list jump");
        print_verdict;
    end
endmodule : dlcg_top_tb
